// file: common/ipc_pkg.sv
// Purpose: shared types for the incremental position counter
// Assumes: ipc_regs.svh gives the widths
// Notes:   thresholds travel as one packed pair per track
`include "ipc_regs.svh"
package ipc_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic signed [`IPC_SAMPLE_W-1:0] ipc_sample_type;

    typedef struct packed {
        ipc_sample_type on_level;
        ipc_sample_type off_level;
    } ipc_thresh_type;

    typedef enum logic [0:0] {
        IPC_DIR_DOWN = 1'b0,
        IPC_DIR_UP   = 1'b1
    } ipc_dir_type;

endpackage

// file: common/ipc_regs.svh
// Purpose: constants for the incremental position counter
// Assumes: signed two's-complement track samples
// Notes:   widths are defaults; only the position width is a module parameter (POS_W)
`ifndef IPC_REGS_SVH
`define IPC_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IPC_SAMPLE_W 12
`define IPC_POS_W    16
`define IPC_SQ_W     25

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IPC_POS_RESET 16'h0000

`endif

// file: src/ipc_counter.sv
// Purpose: incremental position from sine and cosine tracks
// Assumes: track samples and controls are synchronous to clk
// Notes:   square waves pass a two-flop stage before decoding
`timescale 1ns/1ns
`include "ipc_regs.svh"
module ipc_counter #(
    parameter int POS_W = `IPC_POS_W
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Track samples and shaper thresholds
    input  wire ipc_pkg::ipc_sample_type cos_sample,
    input  wire ipc_pkg::ipc_sample_type sin_sample,
    input  wire ipc_pkg::ipc_thresh_type cos_thresh,
    input  wire ipc_pkg::ipc_thresh_type sin_thresh,
    // Phasor band, squared lengths
    input  wire logic [`IPC_SQ_W-1:0]    len_sq_min,
    input  wire logic [`IPC_SQ_W-1:0]    len_sq_max,
    // Counter load
    input  wire logic                    load,
    input  wire logic [POS_W-1:0]        start_pos,
    // Results
    output logic [POS_W-1:0]             position_q,
    output ipc_pkg::ipc_dir_type         dir_q,
    output logic                         count_pulse_q,
    output logic                         illegal_q,
    output logic                         phasor_fault_q,
    output logic                         cos_square_q,
    output logic                         sin_square_q
);
    import ipc_pkg::*;

    // ------------------------------------------------------------
    // Shapers
    // ------------------------------------------------------------
    logic cos_sq;
    logic sin_sq;

    ipc_shaper u_cos_shaper (
        .clk      (clk),
        .rst      (rst),
        .sample   (cos_sample),
        .thresh   (cos_thresh),
        .square_q (cos_sq)
    );

    ipc_shaper u_sin_shaper (
        .clk      (clk),
        .rst      (rst),
        .sample   (sin_sample),
        .thresh   (sin_thresh),
        .square_q (sin_sq)
    );

    // ------------------------------------------------------------
    // Synchroniser and edge history
    // ------------------------------------------------------------
    // The shapers may later become analogue comparators, so the
    // two-flop stage stays even though the samples are synchronous.
    logic a_s1_q;
    logic b_s1_q;
    logic a_s2_q;
    logic b_s2_q;
    logic a_prev_q;
    logic b_prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_s1_q   <= 1'b0;
            b_s1_q   <= 1'b0;
            a_s2_q   <= 1'b0;
            b_s2_q   <= 1'b0;
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
        end else begin
            a_s1_q   <= cos_sq;
            b_s1_q   <= sin_sq;
            a_s2_q   <= a_s1_q;
            b_s2_q   <= b_s1_q;
            a_prev_q <= a_s2_q;
            b_prev_q <= b_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Quadrature decoder
    // ------------------------------------------------------------
    wire logic        a_edge;
    wire logic        b_edge;
    wire logic        step;
    wire logic        both;
    wire ipc_dir_type dir_d;

    assign a_edge = a_s2_q ^ a_prev_q;
    assign b_edge = b_s2_q ^ b_prev_q;
    assign step   = a_edge ^ b_edge;
    assign both   = a_edge & b_edge;
    // Cosine leading sine counts up; any lead below 180 degrees
    // still gives the right sign, beyond it the sign flips.
    assign dir_d  = ipc_dir_type'(a_s2_q ^ b_prev_q);

    // ------------------------------------------------------------
    // Position counter
    // ------------------------------------------------------------
    logic [POS_W-1:0] position_d;

    assign position_d = load ? start_pos :
        (!step ? position_q :
         (dir_d == IPC_DIR_UP) ? position_q + 1'b1 :
                                 position_q - 1'b1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            position_q    <= POS_W'(`IPC_POS_RESET);
            dir_q         <= IPC_DIR_UP;
            count_pulse_q <= 1'b0;
            illegal_q     <= 1'b0;
        end else begin
            position_q    <= position_d;
            dir_q         <= step ? dir_d : dir_q;
            count_pulse_q <= step;
            illegal_q     <= both;
        end
    end

    // ------------------------------------------------------------
    // Phasor length monitor
    // ------------------------------------------------------------
    // Squares avoid a root; the band limits are given squared.
    wire logic [`IPC_SQ_W-1:0] len_sq;
    wire logic                 out_of_band;

    assign len_sq = `IPC_SQ_W'(cos_sample * cos_sample) +
                    `IPC_SQ_W'(sin_sample * sin_sample);
    assign out_of_band = (len_sq < len_sq_min) || (len_sq > len_sq_max);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phasor_fault_q <= 1'b0;
            cos_square_q   <= 1'b0;
            sin_square_q   <= 1'b0;
        end else begin
            phasor_fault_q <= out_of_band;
            cos_square_q   <= a_s2_q;
            sin_square_q   <= b_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sync_delay: assert property (@(posedge clk) disable iff (rst)
        ##2 (a_s2_q == $past(cos_sq, 2)) && (b_s2_q == $past(sin_sq, 2)))
        else $error("synchroniser delay wrong");
    a_load_takes: assert property (@(posedge clk) disable iff (rst)
        load |=> position_q == $past(start_pos))
        else $error("load did not take start position");
    a_count_up: assert property (@(posedge clk) disable iff (rst)
        (!load && step && dir_d == IPC_DIR_UP)
        |=> count_pulse_q && position_q == POS_W'($past(position_q) + 1'b1))
        else $error("up step wrong");
    a_count_down: assert property (@(posedge clk) disable iff (rst)
        (!load && step && dir_d == IPC_DIR_DOWN)
        |=> position_q == POS_W'($past(position_q) - 1'b1))
        else $error("down step wrong");
    a_hold_idle: assert property (@(posedge clk) disable iff (rst)
        (!load && !count_pulse_q) ##1 (!$past(load) && !count_pulse_q)
        |-> $stable(position_q))
        else $error("position moved without pulse");
    a_single_edge: assert property (@(posedge clk) disable iff (rst)
        ($changed(a_s2_q) != $changed(b_s2_q)) |=> count_pulse_q)
        else $error("edge gave no count pulse");
    a_both_illegal: assert property (@(posedge clk) disable iff (rst)
        ($changed(a_s2_q) && $changed(b_s2_q)) |=> illegal_q && !count_pulse_q)
        else $error("double edge not flagged");
    a_dir_forward: assert property (@(posedge clk) disable iff (rst)
        ($rose(a_s2_q) && !b_s2_q && $stable(b_s2_q)) |=> dir_q == IPC_DIR_UP)
        else $error("forward edge gave down direction");
    a_fault_band: assert property (@(posedge clk) disable iff (rst)
        (len_sq > len_sq_max) ##1 (len_sq >= len_sq_min) |-> phasor_fault_q)
        else $error("phasor fault missed");
    a_fault_clear: assert property (@(posedge clk) disable iff (rst)
        (len_sq >= len_sq_min && len_sq <= len_sq_max) |=> !phasor_fault_q)
        else $error("phasor fault in band");
endmodule

// file: src/ipc_shaper.sv
// Purpose: hysteresis shaper, sampled track to square wave
// Assumes: on_level is above off_level
// Notes:   between thresholds the output keeps its last level
`timescale 1ns/1ns
module ipc_shaper (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Track and thresholds
    input  wire ipc_pkg::ipc_sample_type sample,
    input  wire ipc_pkg::ipc_thresh_type thresh,
    // Square wave
    output logic                         square_q
);
    import ipc_pkg::*;

    wire logic go_high;
    wire logic go_low;
    logic      square_d;

    assign go_high  = (sample >= thresh.on_level);
    assign go_low   = (sample <= thresh.off_level);
    assign square_d = go_high ? 1'b1 : (go_low ? 1'b0 : square_q);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            square_q <= 1'b0;
        end else begin
            square_q <= square_d;
        end
    end

    a_shaper_high: assert property (@(posedge clk) disable iff (rst)
        go_high |=> square_q)
        else $error("shaper did not switch high");
    a_shaper_low: assert property (@(posedge clk) disable iff (rst)
        (go_low && !go_high) |=> !square_q)
        else $error("shaper did not switch low");
endmodule

// file: verification/ipc_sensor.sv
// Purpose: encoder sensor model, sine and cosine track samples
// Assumes: track levels follow the quadrant bits given by the bench
// Notes:   samples swing to +amp or -amp, never stall mid-way
`timescale 1ns/1ns
module ipc_sensor (
    // Quadrant and amplitude
    input  wire logic                    a_hi,
    input  wire logic                    b_hi,
    input  wire ipc_pkg::ipc_sample_type amp,
    // Track samples
    output ipc_pkg::ipc_sample_type      cos_sample,
    output ipc_pkg::ipc_sample_type      sin_sample
);
    import ipc_pkg::*;
    // Small amp lands between thresholds, so hysteresis can be seen
    assign cos_sample = a_hi ? amp : -amp;
    assign sin_sample = b_hi ? amp : -amp;
endmodule

// file: verification/tb_top.sv
// Purpose: self-checking bench for the incremental position counter
// Assumes: thresholds +-100, nominal amplitude 400
// Notes:   inputs change at the falling edge
`timescale 1ns/1ns
module tb_top;
    import ipc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic a_hi = 1'b0;
    logic b_hi = 1'b0;
    logic load = 1'b0;
    logic [15:0] start_pos = 16'h0000;
    logic [15:0] exp_pos = 16'h0000;
    ipc_sample_type amp = 12'h190;
    ipc_sample_type cos_s, sin_s;
    ipc_thresh_type th = {12'h064, 12'hf9c};
    logic [15:0] position_q;
    ipc_dir_type dir_q;
    logic pulse, illegal, fault, cos_sq, sin_sq;
    int n_fail = 0;
    int n_checks = 0;
    int n_pulse = 0;
    int n_ill = 0;
    always #20 clk = ~clk;
    ipc_sensor ipc_sensor_i (.a_hi(a_hi), .b_hi(b_hi), .amp(amp),
        .cos_sample(cos_s), .sin_sample(sin_s));
    ipc_counter #(.POS_W(16)) ipc_counter_i (.clk(clk), .rst(rst),
        .cos_sample(cos_s), .sin_sample(sin_s), .cos_thresh(th),
        .sin_thresh(th), .len_sq_min(25'h001c200),
        .len_sq_max(25'h0099200), .load(load), .start_pos(start_pos),
        .position_q(position_q), .dir_q(dir_q), .count_pulse_q(pulse),
        .illegal_q(illegal), .phasor_fault_q(fault),
        .cos_square_q(cos_sq), .sin_square_q(sin_sq));
    always @(posedge clk) begin
        if (pulse === 1'b1) n_pulse++;
        if (illegal === 1'b1) n_ill++;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Six cycles cover the four-edge latency from sample to count
    task automatic move(input logic a, b);
        @(negedge clk);
        a_hi = a;
        b_hi = b;
        repeat (6) @(negedge clk);
    endtask
    task automatic period(input logic up);
        int p0;
        p0 = n_pulse;
        if (up) begin
            move(1, 0); move(1, 1); move(0, 1); move(0, 0);
        end else begin
            move(0, 1); move(1, 1); move(1, 0); move(0, 0);
        end
        exp_pos = up ? exp_pos + 16'h0004 : exp_pos - 16'h0004;
        chk(n_pulse - p0, 4, "pulses per period");
        chk(position_q, exp_pos, "position");
        chk(dir_q, up, "direction");
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_load;
        @(negedge clk);
        load = 1'b1;
        start_pos = 16'hfffe;
        @(negedge clk);
        load = 1'b0;
        exp_pos = 16'hfffe;
        chk(position_q, exp_pos, "loaded position");
        period(1'b1);
        $display("load and wrap done");
    endtask
    task automatic t_both;
        int p0;
        p0 = n_pulse;
        move(1, 1);
        chk(cos_sq, 1, "cosine wave high");
        chk(sin_sq, 1, "sine wave high");
        move(0, 0);
        chk(sin_sq, 0, "sine wave low");
        chk(n_ill, 2, "illegal pulses");
        chk(n_pulse - p0, 0, "no count on double change");
        chk(position_q, exp_pos, "position held");
        $display("double change done");
    endtask
    task automatic t_hyst;
        move(1, 0);
        chk(cos_sq, 1, "cosine wave high");
        @(negedge clk);
        amp = 12'h032;
        move(0, 0);
        chk(cos_sq, 1, "cosine wave held");
        chk(fault, 1, "low amplitude fault");
        @(negedge clk);
        amp = 12'h190;
        repeat (6) @(negedge clk);
        chk(cos_sq, 0, "cosine wave low");
        chk(fault, 0, "band ok");
        chk(position_q, exp_pos, "position back");
        chk(dir_q, 0, "direction down");
        amp = 12'h320;
        repeat (3) @(negedge clk);
        chk(fault, 1, "high amplitude fault");
        amp = 12'h190;
        repeat (3) @(negedge clk);
        $display("hysteresis and band done");
    endtask
    initial begin
        #2000000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk(position_q, 0, "reset position");
        chk(dir_q, 1, "reset direction");
        repeat (4) @(negedge clk);
        chk(fault, 0, "nominal band");
        period(1'b1);
        period(1'b0);
        $display("forward and reverse done");
        t_load();
        t_both();
        t_hyst();
        conclude();
    end
endmodule
